/* File: core/pao_defines.svh */
// register offsets, field positions, reset values and counts for the adc output port
`ifndef PAO_DEFINES_SVH
`define PAO_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PAO_ADDR_CTRL    8'h00
`define PAO_ADDR_STATUS  8'h04
`define PAO_ADDR_RESULT  8'h08
`define PAO_ADDR_COUNT   8'h0c
`define PAO_ADDR_DIV     8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define PAO_CTRL_SIGNED   0
`define PAO_CTRL_RELEASE  1
`define PAO_CTRL_SLEEP    2
`define PAO_STAT_SLEEP    0
`define PAO_STAT_FILL     1
`define PAO_STAT_VALID    2

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define PAO_CTRL_RESET    3'h0
`define PAO_DIV_RESET     16'h000a
`define PAO_RES_WIDTH     14
`define PAO_LATENCY       10

// ----------------------------------------
// axi responses
// ----------------------------------------
`define PAO_RESP_OKAY     2'h0
`define PAO_RESP_DECERR   2'h3

`endif

/* File: core/pao_pkg.sv */
// types shared by the adc output port modules
package pao_pkg;

	// converter operating mode
	typedef enum logic [1:0] {
		PAO_MODE_SLEEP,
		PAO_MODE_FILL,
		PAO_MODE_RUN
	} pao_mode_t;

endpackage

/* File: core/pao_conv_divider.sv */
// divider that makes the one-cycle convert tick from the system clock
`timescale 1ns/1ps
`default_nettype none

module pao_conv_divider #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// control
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] period,
	// tick out
	output logic                  tick
);

	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] cnt_d;
	logic             wrap;

	// a period of zero or one both give a tick every clock
	assign wrap  = (cnt_q + DIV_W'(1)) >= period;
	assign cnt_d = wrap ? '0 : cnt_q + DIV_W'(1);
	assign tick  = run && wrap;

	// counter restarts while stopped so the first tick after wake is a full period away
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else if (!run) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

`default_nettype wire

/* File: core/pao_delay_line.sv */
// fixed-length shift line that models the converter pipeline
`timescale 1ns/1ps
`default_nettype none

module pao_delay_line #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 10
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// control
	input  wire logic             shift_en,
	input  wire logic             flush,
	// data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage_q [DEPTH];

	// every stage moves together on a convert tick; flush wipes valid marks too
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage_q[i] <= '0;
			end
		end else if (flush) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage_q[i] <= '0;
			end
		end else if (shift_en) begin
			stage_q[0] <= din;
			for (int i = 1; i < DEPTH; i++) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	assign dout = stage_q[DEPTH-1];

endmodule

`default_nettype wire

/* File: core/pao_port.sv */
// adc output port: sample capture, pipeline, coding, output drive and axi4-lite registers
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

`include "pao_defines.svh"

// Summary of operation
// (R1) A new sample is taken from the quantizer input on every convert tick, one per convert period.
// (R2) Each result reaches the output word exactly ten convert ticks after the tick that took it.
// (R3) Every result is driven as one fourteen-bit word whose bits all change together.
// (R4) Bit 13 of the word is the top result bit on the first line and bit 0 the bottom bit on the last.
// (R5) The signed coding select gives two's complement when high and offset binary when low, by flipping the top bit.
// (R6) While the release bit is high the data lines are not driven; while low they are driven.
// (R7) While the sleep request is high conversion stops; while low the converter runs normally.
// (R8) The sample valid strobe is high while the word on the output lines is a valid result.
// (R9) Capture logic samples the word once per convert period while the sample valid strobe is high; the capture model takes a word every clock instead.
module pao_port
	import pao_pkg::*;
#(
	parameter int RES_W   = `PAO_RES_WIDTH,
	parameter int LATENCY = `PAO_LATENCY,
	parameter int DIV_W   = 16
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// quantizer input, raw offset binary code
	input  wire logic [RES_W-1:0]  sample_in,
	// parallel result lines
	output logic      [RES_W-1:0]  result_word,
	output logic                   result_oe,
	output logic                   sample_valid_strobe,
	// axi4-lite write address
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic              signed_coding_select_q;
	logic              release_q;
	logic              sleep_request_q;
	logic [DIV_W-1:0]  div_q;
	logic [31:0]       count_q;
	pao_mode_t         mode_q;
	pao_mode_t         mode_d;

	logic              tick;
	logic              tick_d_q;
	logic [RES_W-1:0]  hold_q;
	logic              hold_valid_q;
	logic [RES_W-1:0]  coded;
	logic [RES_W:0]    pipe_in;
	logic [RES_W:0]    pipe_out;
	logic              pipe_valid;
	logic              flush;

	logic [7:0]        aw_addr_q;
	logic              aw_held_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              w_held_q;
	logic              wr_fire;
	logic              wr_ctrl;
	logic              wr_div;
	logic              wr_known;
	logic              rd_fire;
	logic              rd_known;
	logic [31:0]       rd_word;
	logic [31:0]       ctrl_word;
	logic [31:0]       status_word;

	// ----------------------------------------
	// convert clock and sample capture
	// ----------------------------------------

	// convert ticks are only made while awake, so sleep stops conversion outright
	pao_conv_divider #(
		.DIV_W (DIV_W)
	) u_div (
		.clk    (clk),
		.arst_n (arst_n),
		.run    (!sleep_request_q),                                   // [R7]
		.period (div_q),
		.tick   (tick)
	);

	// top bit flips for two's complement; offset binary passes straight through
	assign coded = signed_coding_select_q ?
		{~sample_in[RES_W-1], sample_in[RES_W-2:0]} : sample_in;    // [R5]

	// track-and-hold stage: one new sample per convert tick
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_q       <= '0;
			hold_valid_q <= 1'b0;
		end else if (flush) begin
			hold_valid_q <= 1'b0;
		end else if (tick) begin
			hold_q       <= coded;                                    // [R1]
			hold_valid_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// pipeline
	// ----------------------------------------

	// hold stage plus LATENCY line stages: the word shows after the LATENCY-th tick, counting the capture tick as zero
	assign pipe_in = {hold_valid_q, hold_q};
	assign flush   = sleep_request_q;

	pao_delay_line #(
		.WIDTH (RES_W + 1),
		.DEPTH (LATENCY)
	) u_pipe (
		.clk      (clk),
		.arst_n   (arst_n),
		.shift_en (tick),                                             // [R2]
		.flush    (flush),
		.din      (pipe_in),
		.dout     (pipe_out)
	);

	assign pipe_valid = pipe_out[RES_W];

	// ----------------------------------------
	// output lines
	// ----------------------------------------

	// the whole word comes from one register stage, so no line can lead another
	assign result_word = pipe_out[RES_W-1:0];                         // [R3] [R4]
	// the lines are always driven internally; only the enable follows the release bit
	assign result_oe   = !release_q;                                  // [R6]
	// gated with sleep so the strobe drops in the same cycle sleep is set
	assign sample_valid_strobe = pipe_valid && !sleep_request_q;      // [R8]

	// ----------------------------------------
	// mode tracking and word counter
	// ----------------------------------------

	// fill covers the ticks after wake before the first valid word is out
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			PAO_MODE_SLEEP: begin
				if (!sleep_request_q) begin
					mode_d = PAO_MODE_FILL;
				end
			end
			PAO_MODE_FILL: begin
				if (sleep_request_q) begin
					mode_d = PAO_MODE_SLEEP;
				end else if (pipe_valid) begin
					mode_d = PAO_MODE_RUN;
				end
			end
			PAO_MODE_RUN: begin
				if (sleep_request_q) begin
					mode_d = PAO_MODE_SLEEP;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= PAO_MODE_FILL;
		end else begin
			mode_q <= mode_d;
		end
	end

	// counts each valid word one clock after it lands; wraps silently
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_d_q <= 1'b0;
			count_q  <= '0;
		end else begin
			tick_d_q <= tick;
			if (tick_d_q && sample_valid_strobe) begin
				count_q <= count_q + 32'h1;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite write path
	// ----------------------------------------

	// address and data are each held once taken, in either order
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_ctrl       = wr_fire && (aw_addr_q == `PAO_ADDR_CTRL);
	assign wr_div        = wr_fire && (aw_addr_q == `PAO_ADDR_DIV);
	assign wr_known      = (aw_addr_q == `PAO_ADDR_CTRL) || (aw_addr_q == `PAO_ADDR_DIV) ||
		(aw_addr_q == `PAO_ADDR_STATUS) || (aw_addr_q == `PAO_ADDR_RESULT) ||
		(aw_addr_q == `PAO_ADDR_COUNT);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_addr_q <= '0;
			aw_held_q <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
			aw_held_q <= 1'b1;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			w_data_q <= '0;
			w_strb_q <= '0;
			w_held_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
			w_held_q <= 1'b1;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	// response is raised on the same edge as the register update
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PAO_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_known ? `PAO_RESP_OKAY : `PAO_RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control bits live in byte 0; the divider takes its two low bytes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			signed_coding_select_q <= 1'(`PAO_CTRL_RESET >> `PAO_CTRL_SIGNED);
			release_q              <= 1'b0;
			sleep_request_q        <= 1'b0;
			div_q                  <= DIV_W'(`PAO_DIV_RESET);
		end else begin
			if (wr_ctrl && w_strb_q[0]) begin
				signed_coding_select_q <= w_data_q[`PAO_CTRL_SIGNED];
				release_q              <= w_data_q[`PAO_CTRL_RELEASE];
				sleep_request_q        <= w_data_q[`PAO_CTRL_SLEEP];
			end
			if (wr_div && w_strb_q[0]) begin
				div_q[7:0] <= w_data_q[7:0];
			end
			if (wr_div && w_strb_q[1]) begin
				div_q[DIV_W-1:8] <= w_data_q[DIV_W-1:8];
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read path
	// ----------------------------------------
	assign ctrl_word = {29'h0, sleep_request_q, release_q, signed_coding_select_q};
	assign status_word = {29'h0, sample_valid_strobe,
		mode_q == PAO_MODE_FILL, mode_q == PAO_MODE_SLEEP};
	assign rd_fire  = s_axi_arvalid && s_axi_arready;
	assign rd_known = (s_axi_araddr[7:2] <= (`PAO_ADDR_DIV >> 2));
	assign s_axi_arready = !s_axi_rvalid;

	// read mux; result reads the word as it stands on the lines
	always_comb begin
		rd_word = 32'h0;
		unique case ({s_axi_araddr[7:2], 2'b00})
			`PAO_ADDR_CTRL:   rd_word = ctrl_word;
			`PAO_ADDR_STATUS: rd_word = status_word;
			`PAO_ADDR_RESULT: rd_word = {{(32-RES_W-1){1'b0}}, pipe_out};
			`PAO_ADDR_COUNT:  rd_word = count_q;
			`PAO_ADDR_DIV:    rd_word = {{(32-DIV_W){1'b0}}, div_q};
			default:          rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `PAO_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_known ? `PAO_RESP_OKAY : `PAO_RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* File: dv/pao_port_props.sv */
// concurrent checks on the pins of the adc output port
`timescale 1ns/1ps
`default_nettype none

`include "pao_defines.svh"

module pao_port_props #(
	parameter int RES_W = 14
) (
	// clock and reset
	input wire logic             clk,
	input wire logic             arst_n,
	// result lines
	input wire logic [RES_W-1:0] result_word,
	input wire logic             result_oe,
	input wire logic             sample_valid_strobe,
	// axi4-lite
	input wire logic [7:0]       s_axi_awaddr,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic [31:0]      s_axi_wdata,
	input wire logic [3:0]       s_axi_wstrb,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic             s_axi_bvalid,
	input wire logic [7:0]       s_axi_araddr,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic [1:0]       s_axi_rresp,
	input wire logic             s_axi_rvalid
);
	// the bench always offers address and data together, so one edge takes both
	wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	logic       pend_q;
	logic [2:0] pdat_q;
	logic [2:0] ctrl_q;

	// shadow control bits, landing one edge after the take just as the real register does
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_q <= 1'b0;
			pdat_q <= 3'h0;
			ctrl_q <= 3'h0;
		end else begin
			pend_q <= wr_take && s_axi_awaddr == `PAO_ADDR_CTRL && s_axi_wstrb[0];
			pdat_q <= s_axi_wdata[2:0];
			if (pend_q) ctrl_q <= pdat_q;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	AST_OE_FOLLOWS_CTRL: assert property (result_oe == !ctrl_q[1])
		else $error("line drive does not follow release bit");
	AST_SLEEP_NO_STROBE: assert property (ctrl_q[2] |-> !sample_valid_strobe)
		else $error("strobe high while sleeping");
	AST_SLEEP_HOLDS_WORD: assert property (ctrl_q[2] [*3] |-> $stable(result_word))
		else $error("word moved while sleeping");
	AST_WAKE_REFILL: assert property ($fell(ctrl_q[2]) |-> !sample_valid_strobe [*8])
		else $error("strobe before pipeline refilled");
	AST_STROBE_NEEDS_RUN: assert property ($rose(sample_valid_strobe) |-> !$past(ctrl_q[2], 9))
		else $error("strobe rose without ten ticks of running");
	AST_WRITE_ANSWERED: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	// reads decode the word index only, so the two low address bits never make an error
	AST_READ_ANSWERED: assert property (rd_take |=> s_axi_rvalid && s_axi_rresp ==
		(($past(s_axi_araddr[7:2]) > 6'h04) ? `PAO_RESP_DECERR : `PAO_RESP_OKAY))
		else $error("read response wrong");
	AST_READ_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
endmodule

bind pao_port pao_port_props #(.RES_W(RES_W)) u_props (.clk(clk), .arst_n(arst_n),
	.result_word(result_word), .result_oe(result_oe), .sample_valid_strobe(sample_valid_strobe),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid));

`default_nettype wire

/* File: dv/pao_capture_model.sv */
// downstream capture logic that takes words off the result lines
`timescale 1ns/1ps
`default_nettype none

module pao_capture_model (
	// clock and reset
	input wire logic   clk,
	input wire logic   arst_n,
	// result lines
	input wire logic [13:0] result_word,
	input wire logic        result_oe,
	input wire logic        sample_valid_strobe,
	// captured word
	output logic [13:0] cap_word,
	output logic        cap_valid
);
	// released lines float, so show the inverse of the last driven word rather than a tidy level
	logic [13:0] last_q;
	wire  [13:0] lines = result_oe ? result_word : ~last_q;

	// one word taken every clock while strobe is high and the lines are driven
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_q    <= 14'h0000;
			cap_word  <= 14'h0000;
			cap_valid <= 1'b0;
		end else begin
			if (result_oe) begin
				last_q <= result_word;
			end
			cap_word  <= lines;
			cap_valid <= sample_valid_strobe && result_oe;
		end
	end
endmodule

`default_nettype wire

/* File: dv/test_pao_port.sv */
// self-checking bench for the adc output port
`timescale 1ns/1ps
`default_nettype none

module test_pao_port;
	import pao_pkg::*;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} pao_row_t;
	logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic result_oe, strobe, cap_valid, coding, chk_on;
	logic [13:0] sample_in, result_word, cap_word;
	logic [13:0] hist [0:15];
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	int failures, checks_done, cyc;
	pao_row_t rows [8] = '{'{0, 8'h10, 32'h0000000a, 2'h0}, '{0, 8'h00, 32'h0, 2'h0}, '{1, 8'h10, 32'h1, 2'h0},
		'{0, 8'h10, 32'h1, 2'h0}, '{1, 8'h04, 32'hff, 2'h0}, '{0, 8'h14, 32'h0, 2'h3},
		'{1, 8'h16, 32'h1, 2'h3}, '{0, 8'h00, 32'h0, 2'h0}};

	pao_port dut (.clk(clk), .arst_n(arst_n), .sample_in(sample_in), .result_word(result_word),
		.result_oe(result_oe), .sample_valid_strobe(strobe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	pao_capture_model u_cap (.clk(clk), .arst_n(arst_n), .result_word(result_word), .result_oe(result_oe),
		.sample_valid_strobe(strobe), .cap_word(cap_word), .cap_valid(cap_valid));

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		if (failures == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// write: address and data offered together, each released once taken, bready held till bvalid
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// stream: record each sample as the design sees it, coded as expected, and check captures
	always @(posedge clk) begin
		hist[cyc % 16] = sample_in ^ {coding, 13'h0};
		sample_in <= sample_in + 14'h1357;
		if (chk_on && cap_valid) cmp({18'h0, cap_word}, {18'h0, hist[(cyc - 12) % 16]});
		cyc++;
	end

	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		print_verdict();
	end

	initial begin
		logic [31:0] d;
		{arst_n, awvalid, wvalid, bready, arvalid, rready, coding, chk_on} = '0;
		{awaddr, araddr, wdata, sample_in, cyc} = '0;
		wstrb = 4'hf;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		// register table: reset values, writes, read-only and unmapped places
		foreach (rows[i]) begin
			if (rows[i].wr) axw(rows[i].a, rows[i].d, resp);
			else begin
				axr(rows[i].a, d, resp);
				cmp(d, rows[i].d);
			end
			cmp({30'h0, resp}, {30'h0, rows[i].r});
		end
		// sleep flushes the pipeline, then each coding runs a while from a clean wake
		for (int c = 0; c < 2; c++) begin
			axw(8'h00, 32'h4 | c, resp);
			repeat (20) @(posedge clk);
			cmp({31'h0, strobe}, 32'h0);
			coding = c[0];
			chk_on = 1'b1;
			axw(8'h00, c, resp);
			repeat (40) @(posedge clk);
			cmp({31'h0, strobe}, 32'h1);
		end
		// release the lines, then drive them again with the stream still aligned
		axw(8'h00, 32'h3, resp);
		cmp({31'h0, result_oe}, 32'h0);
		repeat (10) @(posedge clk);
		axw(8'h00, 32'h1, resp);
		cmp({31'h0, result_oe}, 32'h1);
		repeat (20) @(posedge clk);
		// reset in mid-run brings back the idle levels and the default tick period
		chk_on = 1'b0;
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		cmp({30'h0, result_oe, strobe}, 32'h2);
		arst_n <= 1'b1;
		@(posedge clk);
		axr(8'h10, d, resp);
		cmp(d, 32'h0000000a);
		print_verdict();
	end
endmodule

`default_nettype wire
